// ---- mcs_control_store.sv ----
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mcs_control_store #(
    parameter int LEN_SHORT = 2,
    parameter int LEN_MID = 3,
    parameter int LEN_LONG = 4,
    parameter logic [7:0] START_ADDR = 8'h00
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // from branch logic and datapath
    input wire logic [7:0] branch_alter,
    input wire logic [15:0] instruction_register,
    input wire logic [3:0] bus_addr_low,
    // sequencing
    output logic cycle_end,
    output logic [7:0] microprogram_pointer,
    output logic next_address_ext,
    // control lines from the buffer register
    output logic cycle_length_sel_hi,
    output logic cycle_length_sel_lo,
    output logic clock_stop,
    output logic load_instruction_reg,
    output logic write_gpr_high_byte,
    output logic write_gpr_low_byte,
    output logic load_b_reg,
    output logic load_d_reg,
    output logic load_bus_addr_reg,
    output logic xfer_type_hi,
    output logic xfer_type_lo,
    output logic xfer_start,
    output logic [3:0] discrete_alter_field,
    output logic [2:0] status_word_load_sel,
    output logic alu_mode_sel,
    output logic [3:0] alu_function_sel,
    output logic [3:0] b_constant_sel,
    output logic [1:0] b_mux_high_sel,
    output logic [1:0] b_mux_low_sel,
    output logic [1:0] d_mux_sel,
    output logic bus_addr_mux_sel,
    output logic [4:0] branch_condition_field,
    output logic [3:0] gpr_addr
);
    logic [mcs_pkg::MW_W-1:0] store [mcs_pkg::MW_WORDS];
    logic [mcs_pkg::MW_W-1:0] uword;
    logic [mcs_pkg::MW_W-1:0] fetched;
    logic [7:0] next_ptr;
    logic [3:0] next_gpr;
    mcs_pkg::mcs_state_t state;
    logic ctrl_run, resume_req;
    logic [7:0] load_index;
    logic [31:0] load_lo;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write, timer_en, cycle_pulse;
    logic [31:0] rd_data;
    logic rd_ok;

    // byte-lane merge for partial writes
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // fixed-length microwords held in one flop array
    assign fetched = store[microprogram_pointer];
    // branch result folds into the store output before the pointer
    assign next_ptr = fetched[mcs_pkg::NA_MSB:mcs_pkg::NA_LSB] |
                      branch_alter;

    // current word chooses its own cycle length; a stop word halts it in run, but a step still runs it
    assign timer_en = (state == mcs_pkg::MCS_RUN &&
                       !uword[mcs_pkg::STOP_BIT]) ||
                      state == mcs_pkg::MCS_STEP;

    mcs_cycle_timer #(
        .LEN_SHORT(LEN_SHORT),
        .LEN_MID(LEN_MID),
        .LEN_LONG(LEN_LONG)
    ) u_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(timer_en),
        .len_sel(uword[mcs_pkg::CL_HI:mcs_pkg::CL_LO]),
        .cycle_pulse(cycle_pulse)
    );

    mcs_regaddr_sel u_regaddr (
        .from_src(uword[mcs_pkg::SEL_SRC]),
        .from_dst(uword[mcs_pkg::SEL_DST]),
        .from_ba(uword[mcs_pkg::SEL_BA]),
        .from_uw(uword[mcs_pkg::SEL_UW]),
        .ir_src(instruction_register[8:6]),
        .ir_dst(instruction_register[2:0]),
        .ba_low(bus_addr_low),
        .uw_index(uword[mcs_pkg::RIF_MSB:mcs_pkg::RIF_LSB]),
        .addr(next_gpr)
    );

    // register address follows the buffer one clock later
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gpr_addr <= 4'h0;
        end else begin
            gpr_addr <= next_gpr;
        end
    end

    assign cycle_end = cycle_pulse;

    // one fetch per cycle; buffered word rules while the next is read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            uword <= '0;
            microprogram_pointer <= START_ADDR;
        end else if (state == mcs_pkg::MCS_IDLE) begin
            microprogram_pointer <= START_ADDR;
        end else if (cycle_pulse) begin
            uword <= fetched;
            microprogram_pointer <= next_ptr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= mcs_pkg::MCS_IDLE;
        end else if (!ctrl_run) begin
            state <= mcs_pkg::MCS_IDLE;
        end else begin
            case (state)
                mcs_pkg::MCS_IDLE: begin
                    state <= mcs_pkg::MCS_RUN;
                end
                mcs_pkg::MCS_RUN: begin
                    if (uword[mcs_pkg::STOP_BIT]) begin
                        state <= mcs_pkg::MCS_HALT;
                    end
                end
                mcs_pkg::MCS_HALT: begin
                    if (resume_req) begin
                        state <= mcs_pkg::MCS_STEP;
                    end
                end
                mcs_pkg::MCS_STEP: begin
                    if (cycle_pulse) begin
                        state <= mcs_pkg::MCS_RUN;
                    end
                end
                default: begin
                    state <= mcs_pkg::MCS_IDLE;
                end
            endcase
        end
    end

    // control lines are plain slices of the buffer register
    assign cycle_length_sel_hi = uword[mcs_pkg::CL_HI];
    assign cycle_length_sel_lo = uword[mcs_pkg::CL_LO];
    assign clock_stop = uword[mcs_pkg::STOP_BIT];
    assign load_instruction_reg = uword[mcs_pkg::LIR_BIT];
    assign write_gpr_high_byte = uword[mcs_pkg::WH_BIT];
    assign write_gpr_low_byte = uword[mcs_pkg::WL_BIT];
    assign load_b_reg = uword[mcs_pkg::LB_BIT];
    assign load_d_reg = uword[mcs_pkg::LD_BIT];
    assign load_bus_addr_reg = uword[mcs_pkg::LBA_BIT];
    assign xfer_type_hi = uword[mcs_pkg::XT_HI];
    assign xfer_type_lo = uword[mcs_pkg::XT_LO];
    assign xfer_start = uword[mcs_pkg::XS_BIT];
    assign discrete_alter_field =
        uword[mcs_pkg::DA_MSB:mcs_pkg::DA_LSB];
    assign status_word_load_sel =
        uword[mcs_pkg::PSL_MSB:mcs_pkg::PSL_LSB];
    assign alu_mode_sel = uword[mcs_pkg::ALUM_BIT];
    assign alu_function_sel =
        uword[mcs_pkg::ALU_MSB:mcs_pkg::ALU_LSB];
    assign b_constant_sel = uword[mcs_pkg::BC_MSB:mcs_pkg::BC_LSB];
    assign b_mux_high_sel = uword[mcs_pkg::BMH_MSB:mcs_pkg::BMH_LSB];
    assign b_mux_low_sel = uword[mcs_pkg::BML_MSB:mcs_pkg::BML_LSB];
    assign d_mux_sel = uword[mcs_pkg::DM_MSB:mcs_pkg::DM_LSB];
    assign bus_addr_mux_sel = uword[mcs_pkg::BAM_BIT];
    assign branch_condition_field =
        uword[mcs_pkg::BCF_MSB:mcs_pkg::BCF_LSB];
    // extension bit is passed on but never used as an address here
    assign next_address_ext = uword[mcs_pkg::NA_EXT];

    // write channel: address and data taken in either order
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_axi_bresp <= mcs_pkg::RESP_OKAY;
        end else if (do_write) begin
            if (aw_addr == mcs_pkg::OFS_CTRL ||
                aw_addr == mcs_pkg::OFS_INDEX ||
                aw_addr == mcs_pkg::OFS_LOAD_LO ||
                aw_addr == mcs_pkg::OFS_LOAD_HI) begin
                s_axi_bresp <= mcs_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= mcs_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_run <= 1'b0;
            resume_req <= 1'b0;
        end else if (do_write && w_strb[0] &&
                     aw_addr == mcs_pkg::OFS_CTRL) begin
            ctrl_run <= w_data[mcs_pkg::CTRL_RUN];
            resume_req <= w_data[mcs_pkg::CTRL_RESUME];
        end else begin
            resume_req <= 1'b0;
        end
    end

    // a high-half write commits the staged word and steps the index
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            load_index <= 8'h00;
            load_lo <= 32'h0000_0000;
        end else if (do_write) begin
            if (aw_addr == mcs_pkg::OFS_INDEX && w_strb[0]) begin
                load_index <= w_data[7:0];
            end else if (aw_addr == mcs_pkg::OFS_LOAD_LO) begin
                load_lo <= wmerge(load_lo, w_data, w_strb);
            end else if (aw_addr == mcs_pkg::OFS_LOAD_HI) begin
                load_index <= load_index + 8'h01;
            end
        end
    end

    // store has no reset: contents come only from software
    always_ff @(posedge sys_clk) begin
        if (do_write && aw_addr == mcs_pkg::OFS_LOAD_HI) begin
            store[load_index] <= {w_data[mcs_pkg::HI_W-1:0], load_lo};
        end
    end

    // read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == mcs_pkg::OFS_CTRL) begin
            rd_data[mcs_pkg::CTRL_RUN] = ctrl_run;
        end else if (s_axi_araddr == mcs_pkg::OFS_STATUS) begin
            rd_data[3:0] = state;
            rd_data[15:8] = microprogram_pointer;
        end else if (s_axi_araddr == mcs_pkg::OFS_INDEX) begin
            rd_data[7:0] = load_index;
        end else if (s_axi_araddr == mcs_pkg::OFS_LOAD_LO) begin
            rd_data = store[load_index][31:0];
        end else if (s_axi_araddr == mcs_pkg::OFS_LOAD_HI) begin
            rd_data[mcs_pkg::HI_W-1:0] =
                store[load_index][mcs_pkg::MW_W-1:32];
        end else if (s_axi_araddr == mcs_pkg::OFS_BUF_LO) begin
            rd_data = uword[31:0];
        end else if (s_axi_araddr == mcs_pkg::OFS_BUF_HI) begin
            rd_data[mcs_pkg::HI_W-1:0] = uword[mcs_pkg::MW_W-1:32];
        end else if (s_axi_araddr == mcs_pkg::OFS_START) begin
            rd_data[7:0] = START_ADDR;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mcs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? mcs_pkg::RESP_OKAY : mcs_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- mcs_pkg.sv ----
`default_nettype none
package mcs_pkg;

    // control store geometry; bit positions run 56 down to 00
    localparam int MW_WORDS = 256;
    localparam int MW_TOP = 56;
    localparam int MW_W = MW_TOP + 1;
    localparam int NA_W = 8;
    localparam int GPR_W = 4;

    // microword field positions
    localparam int NA_LSB = 0;
    localparam int NA_MSB = 7;
    localparam int NA_EXT = 8;
    localparam int RIF_LSB = 9;
    localparam int RIF_MSB = 12;
    localparam int SEL_UW = 13;
    localparam int SEL_BA = 14;
    localparam int SEL_DST = 15;
    localparam int SEL_SRC = 16;
    localparam int BCF_LSB = 17;
    localparam int BCF_MSB = 21;
    localparam int BAM_BIT = 22;
    localparam int DM_LSB = 23;
    localparam int DM_MSB = 24;
    localparam int BML_LSB = 25;
    localparam int BML_MSB = 26;
    localparam int BMH_LSB = 27;
    localparam int BMH_MSB = 28;
    localparam int BC_LSB = 29;
    localparam int BC_MSB = 32;
    localparam int ALU_LSB = 33;
    localparam int ALU_MSB = 36;
    localparam int ALUM_BIT = 37;
    localparam int PSL_LSB = 38;
    localparam int PSL_MSB = 40;
    localparam int DA_LSB = 41;
    localparam int DA_MSB = 44;
    localparam int XS_BIT = 45;
    localparam int XT_LO = 46;
    localparam int XT_HI = 47;
    localparam int LBA_BIT = 48;
    localparam int LD_BIT = 49;
    localparam int LB_BIT = 50;
    localparam int WL_BIT = 51;
    localparam int WH_BIT = 52;
    localparam int LIR_BIT = 53;
    localparam int STOP_BIT = 54;
    localparam int CL_LO = 55;
    localparam int CL_HI = 56;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INDEX = 8'h08;
    localparam logic [7:0] OFS_LOAD_LO = 8'h0C;
    localparam logic [7:0] OFS_LOAD_HI = 8'h10;
    localparam logic [7:0] OFS_BUF_LO = 8'h14;
    localparam logic [7:0] OFS_BUF_HI = 8'h18;
    localparam logic [7:0] OFS_START = 8'h1C;

    localparam int CTRL_RUN = 0;
    localparam int CTRL_RESUME = 1;
    localparam int HI_W = MW_W - 32;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MCS_IDLE = 4'h1,
        MCS_RUN = 4'h2,
        MCS_HALT = 4'h4,
        MCS_STEP = 4'h8
    } mcs_state_t;

endpackage
`default_nettype wire

// ---- mcs_cycle_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcs_cycle_timer #(
    parameter int LEN_SHORT = 2,
    parameter int LEN_MID = 3,
    parameter int LEN_LONG = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // control
    input wire logic enable,
    input wire logic [1:0] len_sel,
    // end of processor cycle
    output logic cycle_pulse
);
    logic [7:0] count;
    logic [7:0] last;

    // code 3 has no own length; it falls back to the longest one
    always_comb begin
        case (len_sel)
            2'h0: last = 8'(LEN_SHORT - 1);
            2'h1: last = 8'(LEN_MID - 1);
            default: last = 8'(LEN_LONG - 1);
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !enable) begin
            count <= 8'h00;
            cycle_pulse <= 1'b0;
        end else if (count >= last) begin
            count <= 8'h00;
            cycle_pulse <= 1'b1;
        end else begin
            count <= count + 8'h01;
            cycle_pulse <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- mcs_regaddr_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcs_regaddr_sel (
    // source selects from the microword
    input wire logic from_src,
    input wire logic from_dst,
    input wire logic from_ba,
    input wire logic from_uw,
    // candidate addresses
    input wire logic [2:0] ir_src,
    input wire logic [2:0] ir_dst,
    input wire logic [3:0] ba_low,
    input wire logic [3:0] uw_index,
    // selected general register address
    output logic [3:0] addr
);
    // fixed priority only matters when microcode sets several selects
    always_comb begin
        if (from_src) begin
            addr = {1'b0, ir_src};
        end else if (from_dst) begin
            addr = {1'b0, ir_dst};
        end else if (from_ba) begin
            addr = ba_low;
        end else if (from_uw) begin
            addr = uw_index;
        end else begin
            addr = 4'h0;
        end
    end
endmodule
`default_nettype wire

// ---- mcs_datapath_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcs_datapath_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // control lines from the store
    input wire logic cycle_end,
    input wire logic load_instruction_reg,
    input wire logic load_bus_addr_reg,
    input wire logic [4:0] branch_condition_field,
    // bench stimulus
    input wire logic [15:0] bus_data,
    input wire logic [7:0] alter_mask,
    // datapath state seen by the store
    output logic [15:0] instruction_register,
    output logic [3:0] bus_addr_low,
    output logic [7:0] branch_alter
);
    // loads land at the end of the cycle whose word asked for them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            instruction_register <= 16'h0000;
        end else if (cycle_end && load_instruction_reg) begin
            instruction_register <= bus_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_addr_low <= 4'h0;
        end else if (cycle_end && load_bus_addr_reg) begin
            bus_addr_low <= bus_data[3:0];
        end
    end
    // only condition 01 is modelled, and it always tests true
    assign branch_alter = (branch_condition_field == 5'h01) ?
        alter_mask : 8'h00;
endmodule
`default_nettype wire

// ---- mcs_cs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcs_cs_chk #(
    parameter int LEN_SHORT = 2,
    parameter int LEN_MID = 3,
    parameter int LEN_LONG = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // sequencing
    input wire logic cycle_end,
    input wire logic [7:0] microprogram_pointer,
    input wire logic [7:0] branch_alter,
    // control lines
    input wire logic cycle_length_sel_hi,
    input wire logic cycle_length_sel_lo,
    input wire logic clock_stop,
    input wire logic [3:0] alu_function_sel,
    input wire logic [4:0] branch_condition_field,
    // register bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [7:0] gap;
    logic seen;
    logic [7:0] exp_len;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    assign exp_len = cycle_length_sel_hi ? 8'(LEN_LONG) :
        (cycle_length_sel_lo ? 8'(LEN_MID) : 8'(LEN_SHORT));
    // gap saturates so a long halt cannot wrap into a false match
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else if (cycle_end) begin
            gap <= 8'h01;
            seen <= 1'b1;
        end else if (gap != 8'hFF) begin
            gap <= gap + 8'h01;
        end
    end
    sequence s_stop_rise;
        $rose(clock_stop);
    endsequence
    sequence s_no_end;
        !cycle_end [*4];
    endsequence
    AST_CE_ONE: assert property (cycle_end |=> !cycle_end)
        else $error("cycle end wider than one clock");
    AST_LEN: assert property (
        cycle_end && seen && !clock_stop |-> gap == exp_len)
        else $error("cycle length differs from selected length");
    AST_STOP: assert property (s_stop_rise |=> s_no_end)
        else $error("cycle ended while clock stopped");
    AST_HOLD: assert property (
        !cycle_end |=> $stable({alu_function_sel, branch_condition_field,
        cycle_length_sel_hi, cycle_length_sel_lo}))
        else $error("control lines changed inside a cycle");
    AST_PTR_HOLD: assert property (
        !cycle_end |=> $stable(microprogram_pointer))
        else $error("pointer moved without cycle end");
    AST_PTR_ALT: assert property (cycle_end |=>
        (microprogram_pointer & $past(branch_alter)) == $past(branch_alter))
        else $error("branch alteration lost in next pointer");
    AST_B_DONE: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    AST_R_DONE: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after handshake");
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
    logic sys_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cycle_end;
    logic next_address_ext, cycle_length_sel_hi, cycle_length_sel_lo;
    logic clock_stop, load_instruction_reg, write_gpr_high_byte;
    logic write_gpr_low_byte, load_b_reg, load_d_reg, load_bus_addr_reg;
    logic xfer_type_hi, xfer_type_lo, xfer_start, alu_mode_sel;
    logic bus_addr_mux_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, b_mux_high_sel, b_mux_low_sel;
    logic [1:0] d_mux_sel;
    logic [2:0] status_word_load_sel;
    logic [3:0] s_axi_wstrb, bus_addr_low, discrete_alter_field, gpr_addr;
    logic [3:0] alu_function_sel, b_constant_sel;
    logic [4:0] branch_condition_field;
    logic [7:0] s_axi_awaddr, s_axi_araddr, branch_alter, alter_mask;
    logic [7:0] microprogram_pointer;
    logic [15:0] instruction_register, bus_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [39:0] ctl;
    logic [56:0] w0, w1, w2, w7, w8;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign ctl = {cycle_length_sel_hi, cycle_length_sel_lo, clock_stop,
        load_instruction_reg, write_gpr_high_byte, write_gpr_low_byte,
        load_b_reg, load_d_reg, load_bus_addr_reg, xfer_type_hi,
        xfer_type_lo, xfer_start, discrete_alter_field, status_word_load_sel,
        alu_mode_sel, alu_function_sel, b_constant_sel, b_mux_high_sel,
        b_mux_low_sel, d_mux_sel, bus_addr_mux_sel, branch_condition_field};
    mcs_control_store i_dut (.*);
    mcs_datapath_model i_dp (.*);
    function automatic logic [56:0] mkw(input logic [1:0] cl,
        input logic stp, input logic [31:0] misc, input logic [4:0] bcf,
        input logic [3:0] sel, input logic [3:0] microword_reg_index, input logic [7:0] nx);
        return {cl, stp, misc, bcf, sel, microword_reg_index, nx == 8'h00, nx};
    endfunction
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", r, s_axi_bresp)
        // an edge passes so the next call never reassigns the ready
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK("rresp", r, s_axi_rresp)
        if (r === mcs_pkg::RESP_OKAY) `CHK("rdata", e, s_axi_rdata)
        @(posedge sys_clk);
    endtask
    task automatic ld(input logic [7:0] i, input logic [56:0] w);
        wr(mcs_pkg::OFS_INDEX, {24'h000000, i}, mcs_pkg::RESP_OKAY);
        wr(mcs_pkg::OFS_LOAD_LO, w[31:0], mcs_pkg::RESP_OKAY);
        wr(mcs_pkg::OFS_LOAD_HI, {7'h00, w[56:32]}, mcs_pkg::RESP_OKAY);
    endtask
    // entered at a rising edge; returns two edges after the buffer loads
    task automatic step_chk(input logic [56:0] w, input logic [7:0] p,
        input logic [3:0] g);
        while (cycle_end !== 1'b1) @(posedge sys_clk);
        #1;
        `CHK("clk", w[56:54], ctl[39:37])
        `CHK("load", w[53:45], ctl[36:28])
        `CHK("alu", w[44:33], ctl[27:16])
        `CHK("mux", w[32:17], ctl[15:0])
        `CHK("ext", w[8], next_address_ext)
        `CHK("ptr", p, microprogram_pointer)
        @(posedge sys_clk);
        #1;
        `CHK("gpr", g, gpr_addr)
        @(posedge sys_clk);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        srst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        bus_data = 16'h01CA;
        alter_mask = 8'h04;
        w0 = mkw(2'h0, 1'b0, 32'hA5C35A3C, 5'h00, 4'h1, 4'h3, 8'h01);
        w1 = mkw(2'h1, 1'b0, 32'h5A3CA5C3, 5'h01, 4'h8, 4'h0, 8'h02);
        w2 = mkw(2'h2, 1'b0, 32'h0F0FF0F0, 5'h00, 4'h4, 4'h0, 8'h03);
        w7 = mkw(2'h3, 1'b1, 32'hFFFFFFFF, 5'h1E, 4'h3, 4'h5, 8'h08);
        w8 = mkw(2'h0, 1'b1, 32'h00000000, 5'h00, 4'h0, 4'h9, 8'h00);
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        ld(8'h00, w0);
        ld(8'h01, w1);
        ld(8'h02, w2);
        ld(8'h07, w7);
        ld(8'h08, w8);
        ld(8'hFF, w2);
        wr(mcs_pkg::OFS_INDEX, 32'h000000FF, mcs_pkg::RESP_OKAY);
        rd(mcs_pkg::OFS_LOAD_LO, w2[31:0], mcs_pkg::RESP_OKAY);
        rd(mcs_pkg::OFS_LOAD_HI, {7'h00, w2[56:32]}, 2'h0);
        rd(8'h20, 32'h00000000, mcs_pkg::RESP_SLVERR);
        wr(mcs_pkg::OFS_STATUS, 32'h00000000, mcs_pkg::RESP_SLVERR);
        rd(mcs_pkg::OFS_STATUS, 32'h00000001, mcs_pkg::RESP_OKAY);
        wr(mcs_pkg::OFS_CTRL, 32'h00000001, mcs_pkg::RESP_OKAY);
        step_chk(w0, 8'h01, 4'h3);
        step_chk(w1, 8'h02, 4'h7);
        step_chk(w2, 8'h07, 4'h2);
        step_chk(w7, 8'h08, 4'hA);
        rd(mcs_pkg::OFS_STATUS, 32'h00000804, 2'h0);
        wr(mcs_pkg::OFS_CTRL, 32'h00000003, mcs_pkg::RESP_OKAY);
        step_chk(w8, 8'h00, 4'h0);
        rd(mcs_pkg::OFS_STATUS, 32'h00000004, 2'h0);
        rd(mcs_pkg::OFS_BUF_LO, w8[31:0], 2'h0);
        rd(mcs_pkg::OFS_BUF_HI, {7'h00, w8[56:32]}, 2'h0);
        rd(mcs_pkg::OFS_CTRL, 32'h00000001, 2'h0);
        rd(mcs_pkg::OFS_START, 32'h00000000, 2'h0);
        finish_test();
    end
endmodule
bind mcs_control_store mcs_cs_chk #(.LEN_SHORT(LEN_SHORT),
    .LEN_MID(LEN_MID), .LEN_LONG(LEN_LONG)) i_chk (.*);
`default_nettype wire
